// [inc/msegen_pkg.sv]
/*
 Package for the seven-stage contour generator: stage enumeration,
 level and time widths, timing constants and reset values.
 Assumes a 100 MHz clock and a sample tick supplied by the system.
*/
`default_nettype none

package msegen_pkg;

	// Level field widths and limits, in user units of one percent
	localparam int        LEVEL_W        = 8;
	localparam logic [7:0] LEVEL_MAX     = 8'h64;  // +100
	localparam logic [7:0] LEVEL_MIN_NEG = 8'h9c;  // -100 signed
	localparam logic [7:0] LEVEL_ZERO    = 8'h00;

	// Output sample width toward the converter
	localparam int        OUT_W          = 16;
	localparam int        ACC_W          = 32;
	localparam int        FRAC_W         = 16;

	// Stage time field; one unit is one sample tick, all ones is "infinite" for second release only
	localparam int        TIME_W         = 16;
	localparam logic [15:0] TIME_ZERO    = 16'h0000;
	localparam logic [15:0] TIME_INF     = 16'hffff;

	// Shortest attack and second release, 2 ms at the sample rate
	localparam int        MIN_TIME_US    = 2000;
	localparam int        TICK_US        = 20;     // 50 kHz sample tick
	localparam int        MIN_TICKS_I    = (MIN_TIME_US + TICK_US - 1) / TICK_US;
	localparam logic [15:0] MIN_TICKS    = 16'(MIN_TICKS_I);

	// Trigger mode selector codes
	localparam logic [1:0] MODE_NORMAL   = 2'h0;
	localparam logic [1:0] MODE_MODTRIG  = 2'h1;
	localparam logic [1:0] MODE_MODGATE  = 2'h2;

	// Number of contour instances in a voice
	localparam int        NUM_GENS       = 3;

	// Stages of one contour
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DELAY,
		ST_ATTACK,
		ST_DECAY1,
		ST_DECAY2,
		ST_SUSTAIN,
		ST_RELEASE1,
		ST_RELEASE2
	} msegen_stage_e;

endpackage

`default_nettype wire

// [rtl/msegen_core.sv]
/*
 One contour generator: seven stages from delay to second release,
 linear ramps toward each target level over the programmed time.
 Assumes note events and the sample tick are one-cycle pulses
 synchronous to clk, and settings stay steady while a stage runs.
*/
`timescale 1ns/100ps
`default_nettype none

module msegen_core #(
	parameter bit BIPOLAR = 1'b1
) (
	input  wire logic                            clk,
	input  wire logic                            reset,
	input  wire logic                            sampleTick,
	input  wire logic                            noteOn,
	input  wire logic                            noteOff,
	input  wire logic [15:0]                     delayDuration,
	input  wire logic [15:0]                     attackDuration,
	input  wire logic [15:0]                     firstDecayDuration,
	input  wire logic [15:0]                     secondDecayDuration,
	input  wire logic [15:0]                     firstReleaseDuration,
	input  wire logic [15:0]                     secondReleaseDuration,
	input  wire logic [7:0]                      attackTarget,
	input  wire logic [7:0]                      secondDecayTarget,
	input  wire logic [7:0]                      sustainTarget,
	input  wire logic [7:0]                      secondReleaseTarget,
	input  wire logic                            invertPolarity,
	output logic signed [15:0]                   level,
	output msegen_pkg::msegen_stage_e            stage
);

	// Stage register and its next value
	msegen_pkg::msegen_stage_e stage_q, stage_d;
	// Level accumulator with fraction bits, signed
	logic signed [31:0]        acc_q, acc_d;
	// Per-tick step for the running ramp
	logic signed [31:0]        step_q, step_d;
	// Ticks left in the running stage
	logic [15:0]               left_q, left_d;
	// Note still held
	logic                      held_q, held_d;

	// Working values for stage entry
	msegen_pkg::msegen_stage_e nxtStage;
	logic signed [31:0]        tgtAcc;
	logic [15:0]               dur;
	logic signed [31:0]        curTarget;

	// Clamp a level setting into the legal range of this instance
	function automatic logic signed [7:0] clampLevel(input logic [7:0] v);
		logic signed [7:0] s;
		s = signed'(v);
		if (BIPOLAR)
		begin
			if (s > signed'(msegen_pkg::LEVEL_MAX))
				clampLevel = signed'(msegen_pkg::LEVEL_MAX);
			else if (s < signed'(msegen_pkg::LEVEL_MIN_NEG))
				clampLevel = signed'(msegen_pkg::LEVEL_MIN_NEG);
			else
				clampLevel = s;
		end
		else
		begin
			if (s < 0)
				clampLevel = 8'sh00;
			else if (s > signed'(msegen_pkg::LEVEL_MAX))
				clampLevel = signed'(msegen_pkg::LEVEL_MAX);
			else
				clampLevel = s;
		end
	endfunction

	// Target level for a stage, in accumulator units
	function automatic logic signed [31:0] targetOf(input msegen_pkg::msegen_stage_e s);
		logic signed [7:0] l;
		l = 8'sh00;
		case (s)
			msegen_pkg::ST_ATTACK:   l = clampLevel(attackTarget);
			msegen_pkg::ST_DECAY1:   l = clampLevel(secondDecayTarget);
			msegen_pkg::ST_DECAY2:   l = clampLevel(sustainTarget);
			msegen_pkg::ST_SUSTAIN:  l = clampLevel(sustainTarget);
			msegen_pkg::ST_RELEASE1: l = clampLevel(secondReleaseTarget);
			default:                 l = 8'sh00;
		endcase
		targetOf = 32'(signed'(l)) <<< msegen_pkg::FRAC_W;
	endfunction

	// Programmed duration for a stage, floors applied
	function automatic logic [15:0] durOf(input msegen_pkg::msegen_stage_e s);
		case (s)
			msegen_pkg::ST_DELAY:    durOf = delayDuration;
			msegen_pkg::ST_ATTACK:   durOf = (attackDuration < msegen_pkg::MIN_TICKS)
				? msegen_pkg::MIN_TICKS : attackDuration;
			msegen_pkg::ST_DECAY1:   durOf = firstDecayDuration;
			msegen_pkg::ST_DECAY2:   durOf = secondDecayDuration;
			msegen_pkg::ST_RELEASE1: durOf = firstReleaseDuration;
			msegen_pkg::ST_RELEASE2: durOf = (secondReleaseDuration < msegen_pkg::MIN_TICKS)
				? msegen_pkg::MIN_TICKS : secondReleaseDuration;
			default:                 durOf = msegen_pkg::TIME_ZERO;
		endcase
	endfunction

	// Stage after the given one, skipping zero-time stages
	function automatic msegen_pkg::msegen_stage_e after(input msegen_pkg::msegen_stage_e s);
		msegen_pkg::msegen_stage_e n;
		n = msegen_pkg::ST_IDLE;
		case (s)
			msegen_pkg::ST_DELAY:   n = msegen_pkg::ST_ATTACK;
			msegen_pkg::ST_ATTACK:  n = msegen_pkg::ST_DECAY1;
			default:                n = msegen_pkg::ST_IDLE;
		endcase
		if (n == msegen_pkg::ST_DECAY1 && firstDecayDuration == msegen_pkg::TIME_ZERO)
			n = msegen_pkg::ST_DECAY2;
		if (s == msegen_pkg::ST_DECAY1)
			n = msegen_pkg::ST_DECAY2;
		if (n == msegen_pkg::ST_DECAY2 && secondDecayDuration == msegen_pkg::TIME_ZERO)
			n = msegen_pkg::ST_SUSTAIN;
		if (s == msegen_pkg::ST_DECAY2)
			n = msegen_pkg::ST_SUSTAIN;
		if (n == msegen_pkg::ST_SUSTAIN && sustainTarget == msegen_pkg::LEVEL_ZERO)
			n = msegen_pkg::ST_RELEASE1;
		if (s == msegen_pkg::ST_RELEASE1)
			n = msegen_pkg::ST_RELEASE2;
		if (n == msegen_pkg::ST_RELEASE1 && firstReleaseDuration == msegen_pkg::TIME_ZERO)
			n = msegen_pkg::ST_RELEASE2;
		after = n;
	endfunction

	// Stage sequencing and ramp arithmetic
	always_comb
	begin
		stage_d   = stage_q;
		acc_d     = acc_q;
		step_d    = step_q;
		left_d    = left_q;
		held_d    = held_q;
		nxtStage  = stage_q;
		tgtAcc    = 32'sh0;
		dur       = 16'h0000;
		curTarget = targetOf(stage_q);
		if (noteOn)
		begin
			held_d   = 1'b1;
			nxtStage = msegen_pkg::ST_DELAY;
		end
		else if (noteOff && held_q)
		begin
			held_d   = 1'b0;
			nxtStage = (firstReleaseDuration == msegen_pkg::TIME_ZERO)
				? msegen_pkg::ST_RELEASE2 : msegen_pkg::ST_RELEASE1;
		end
		else if (sampleTick)
		begin
			case (stage_q)
				msegen_pkg::ST_IDLE, msegen_pkg::ST_SUSTAIN:
				begin
					nxtStage = stage_q;
				end
				msegen_pkg::ST_RELEASE2:
				begin
					if (secondReleaseDuration == msegen_pkg::TIME_INF)
						nxtStage = stage_q;
					else if (left_q <= 16'h0001)
					begin
						acc_d    = 32'sh0;
						nxtStage = msegen_pkg::ST_IDLE;
					end
					else
					begin
						acc_d  = acc_q + step_q;
						left_d = left_q - 16'h0001;
					end
				end
				default:
				begin
					if (left_q <= 16'h0001)
					begin
						if (stage_q != msegen_pkg::ST_DELAY)
							acc_d = curTarget;
						nxtStage = after(stage_q);
						if (!held_q && nxtStage != msegen_pkg::ST_RELEASE2)
							nxtStage = msegen_pkg::ST_RELEASE1;
					end
					else
					begin
						acc_d  = acc_q + step_q;
						left_d = left_q - 16'h0001;
					end
				end
			endcase
		end
		// Stage entry loads time and slope
		if (nxtStage != stage_q || noteOn || (noteOff && held_q))
		begin
			stage_d = nxtStage;
			if (nxtStage == msegen_pkg::ST_DELAY && delayDuration == msegen_pkg::TIME_ZERO)
				stage_d = msegen_pkg::ST_ATTACK;
			dur    = durOf(stage_d);
			tgtAcc = targetOf(stage_d);
			left_d = dur;
			if (stage_d == msegen_pkg::ST_IDLE || stage_d == msegen_pkg::ST_DELAY
				|| stage_d == msegen_pkg::ST_SUSTAIN || dur == msegen_pkg::TIME_ZERO)
				step_d = 32'sh0;
			else
				step_d = (tgtAcc - acc_d) / signed'({16'h0000, dur});
			// sustain sits at its level
			// Skipped decays would otherwise leave the attack level standing
			if (stage_d == msegen_pkg::ST_SUSTAIN)
				acc_d = tgtAcc;
			if (stage_d == msegen_pkg::ST_IDLE)
				acc_d = 32'sh0;
		end
	end

	// State registers
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			stage_q <= msegen_pkg::ST_IDLE;
			acc_q   <= 32'sh0;
			step_q  <= 32'sh0;
			left_q  <= 16'h0000;
			held_q  <= 1'b0;
		end
		else
		begin
			stage_q <= stage_d;
			acc_q   <= acc_d;
			step_q  <= step_d;
			left_q  <= left_d;
			held_q  <= held_d;
		end
	end

	// Output level scaled to 16 bits, polarity flip on bipolar only
	logic signed [15:0] level_q;
	logic signed [15:0] level_d;
	always_comb
	begin
		if (BIPOLAR && invertPolarity)
			level_d = -acc_q[23:8];
		else
			level_d = acc_q[23:8];
	end

	// Registered converter value
	always_ff @(posedge clk)
	begin
		if (reset)
			level_q <= 16'sh0000;
		else
			level_q <= level_d;
	end

	assign level = level_q;
	assign stage = stage_q;

	// Idle contour rests at zero
	property p_idle_zero;
		@(posedge clk) disable iff (reset) stage_q == msegen_pkg::ST_IDLE |-> acc_q == 32'sh0;
	endproperty
	a_idle_zero: assert property (p_idle_zero) else $error("idle contour not at zero");

endmodule

`default_nettype wire

// [rtl/msegen_voice.sv]
/*
 One voice worth of contour generators: pitch, filter and amplitude
 instances, trigger mode gating and the fixed amplifier feed.
 Assumes note events come as one-cycle pulses on clk and the sample
 tick is a one-cycle pulse from the system timebase.
*/
// Notes on behaviour
// - three seven-stage generators per voice
// - contour starts and ends at zero
// - each target reached over its time
// - note on runs delay through decays
// - normal mode holds sustain while held
// - note off runs both release stages
// - bipolar levels span minus to plus hundred
// - amplitude levels span zero to hundred
// - amplitude contour always feeds amplifier
// - zero decay or release time skips; a zero second release time is raised to the 2ms floor instead
// - zero sustain level bypasses sustain
// - trigger settings need modulation trigger mode
// - amplitude instance has no polarity setting
// - delay elapses before attack begins
// - attack and second release at least 2ms
// - maximum second release holds forever
`timescale 1ns/100ps
`default_nettype none

module msegen_voice (
	input  wire logic                 clk,
	input  wire logic                 reset,
	input  wire logic                 sampleTick,
	input  wire logic                 noteOn,
	input  wire logic                 noteOff,
	input  wire logic                 modTrigger,
	input  wire logic [1:0]           triggerMode,
	input  wire logic                 triggerEnable,
	input  wire logic [47:0]          delayDuration,
	input  wire logic [47:0]          attackDuration,
	input  wire logic [47:0]          firstDecayDuration,
	input  wire logic [47:0]          secondDecayDuration,
	input  wire logic [47:0]          firstReleaseDuration,
	input  wire logic [47:0]          secondReleaseDuration,
	input  wire logic [23:0]          attackTarget,
	input  wire logic [23:0]          secondDecayTarget,
	input  wire logic [23:0]          sustainTarget,
	input  wire logic [23:0]          secondReleaseTarget,
	input  wire logic [1:0]           invertPolarity,
	output logic signed [15:0]        pitchContour,
	output logic signed [15:0]        filterContour,
	output logic signed [15:0]        ampContour,
	output logic signed [15:0]        ampFeed
);

	// Effective start and stop pulses toward the generators
	logic startPulse;
	logic stopPulse;
	// Instance levels
	logic signed [15:0] lvl [3];

	always_comb
	begin
		startPulse = noteOn;
		stopPulse  = noteOff;
		if ((triggerMode == msegen_pkg::MODE_MODTRIG
			|| triggerMode == msegen_pkg::MODE_MODGATE) && triggerEnable)
			startPulse = noteOn | modTrigger;
	end

	for (genvar g = 0; g < msegen_pkg::NUM_GENS; g++)
	begin : gen_env
		msegen_core #(
			.BIPOLAR (g < 2)
		) u_env (
			.clk                   (clk),
			.reset                 (reset),
			.sampleTick            (sampleTick),
			.noteOn                (startPulse),
			.noteOff               (stopPulse),
			.delayDuration         (delayDuration[16*g +: 16]),
			.attackDuration        (attackDuration[16*g +: 16]),
			.firstDecayDuration    (firstDecayDuration[16*g +: 16]),
			.secondDecayDuration   (secondDecayDuration[16*g +: 16]),
			.firstReleaseDuration  (firstReleaseDuration[16*g +: 16]),
			.secondReleaseDuration (secondReleaseDuration[16*g +: 16]),
			.attackTarget          (attackTarget[8*g +: 8]),
			.secondDecayTarget     (secondDecayTarget[8*g +: 8]),
			.sustainTarget         (sustainTarget[8*g +: 8]),
			.secondReleaseTarget   (secondReleaseTarget[8*g +: 8]),
			.invertPolarity        ((g < 2) ? invertPolarity[g % 2] : 1'b0),
			.level                 (lvl[g]),
			.stage                 ()
		);
	end

	assign pitchContour  = lvl[0];
	assign filterContour = lvl[1];
	assign ampContour    = lvl[2];
	assign ampFeed       = lvl[2];

	// Unipolar instance never goes negative
	property p_amp_nonneg;
		@(posedge clk) disable iff (reset) ampFeed >= 0;
	endproperty
	a_amp_nonneg: assert property (p_amp_nonneg) else $error("amp contour negative");

	// Feed equals contour
	property p_feed;
		@(posedge clk) disable iff (reset) ampFeed == ampContour;
	endproperty
	a_feed: assert property (p_feed) else $error("amp feed detached");

	// Bipolar range bound, 100 scaled
	property p_range;
		@(posedge clk) disable iff (reset)
			pitchContour <= 16'sh6400 && pitchContour >= -16'sh6400;
	endproperty
	a_range: assert property (p_range) else $error("pitch contour out of range");

	// Without trigger mode the modulation trigger has no effect
	property p_gate;
		@(posedge clk) disable iff (reset)
			(triggerMode == msegen_pkg::MODE_NORMAL && !noteOn) |-> !startPulse;
	endproperty
	a_gate: assert property (p_gate) else $error("trigger leaked in normal mode");

	// One quiet cycle, then the output register stage
	sequence s_quiet_cycle;
		(!sampleTick && !noteOn && !noteOff) ##1 1'b1;
	endsequence

	// Level changes only after a tick or note event
	property p_tick;
		@(posedge clk) disable iff (reset)
			s_quiet_cycle |-> ##1 $stable(ampContour);
	endproperty
	a_tick: assert property (p_tick) else $error("level moved without tick");

	// Note off is passed through
	property p_stop;
		@(posedge clk) disable iff (reset) noteOff |-> stopPulse;
	endproperty
	a_stop: assert property (p_stop) else $error("note off lost");

	// Note on is always passed through
	property p_start;
		@(posedge clk) disable iff (reset) noteOn |-> startPulse;
	endproperty
	a_start: assert property (p_start) else $error("note on lost");

endmodule

`default_nettype wire

// [testbench/msegen_partner.sv]
/*
 Far side of one voice: note event source, sample tick timebase and
 the amplifier that listens to the amplitude contour.
 Assumes the bench calls its tasks just after a falling clock edge.
*/
`timescale 1ns/100ps
`default_nettype none

module msegen_partner #(
	parameter int TICK_DIV = 2
) (
	input  wire logic               clk,
	input  wire logic               reset,
	output logic                    sampleTick,
	output logic                    noteOn,
	output logic                    noteOff,
	input  wire logic signed [15:0] ampContour,
	input  wire logic signed [15:0] ampFeed,
	output logic                    feedFault
);
	int tickCnt;   // Divider toward the sample tick
	bit held;      // A key is down

	// tick timebase
	// Free running, so contours advance even across note gaps
	initial
	begin
		tickCnt = 0;
		sampleTick = 1'b0;
		noteOn = 1'b0;
		noteOff = 1'b0;
		held = 1'b0;
		forever
		begin
			@(negedge clk);
			sampleTick = (tickCnt == 0);
			tickCnt = (tickCnt + 1) % TICK_DIV;
		end
	end

	// amplifier feed
	// The amplifier must see the amplitude contour at all times
	always @(posedge clk)
		if (reset)
			feedFault <= 1'b0;
		else if (ampFeed !== ampContour)
			feedFault <= 1'b1;

	// Key down, one clock pulse
	task automatic press();
		noteOn = 1'b1;
		held = 1'b1;
		@(negedge clk);
		noteOn = 1'b0;
	endtask

	// Key up, only sent when a key is down
	task automatic letGo();
		if (held)
		begin
			noteOff = 1'b1;
			held = 1'b0;
			@(negedge clk);
			noteOff = 1'b0;
		end
	endtask

	// Wait a number of sample ticks, ends on a falling edge
	task automatic waitTicks(input int n);
		repeat (n * TICK_DIV) @(negedge clk);
	endtask
endmodule

`default_nettype wire

// [testbench/msegen_voice_tb.sv]
/*
 Self-checking bench for one voice of contour generators.
 Assumes the partner drives ticks and notes; levels are checked at
 settled points of each contour against a model of targets.
*/
`timescale 1ns/100ps
`default_nettype none

module msegen_voice_tb;
	logic clk, reset, modTrigger, triggerEnable;  // Bench driven controls
	logic sampleTick, noteOn, noteOff, feedFault; // Partner side
	logic [1:0] triggerMode, invertPolarity;      // Mode and flips
	logic [47:0] dlyD, atkD, d1D, d2D, r1D, r2D;  // Stage times
	logic [23:0] atkT, d2T, susT, relT;           // Packed targets
	logic signed [15:0] pitchC, filterC, ampC, ampF; // Contours
	int n_errors, checks_done;   // Verdict counters
	int seed;                    // Random seed
	int aT[3], sT[3], rT[3];     // Targets per instance
	int expQ[$];                 // Expected levels waiting

	msegen_partner #(.TICK_DIV(2)) prt (.clk(clk), .reset(reset),
		.sampleTick(sampleTick), .noteOn(noteOn), .noteOff(noteOff),
		.ampContour(ampC), .ampFeed(ampF), .feedFault(feedFault));

	msegen_voice dut_u (.clk(clk), .reset(reset), .sampleTick(sampleTick),
		.noteOn(noteOn), .noteOff(noteOff), .modTrigger(modTrigger),
		.triggerMode(triggerMode), .triggerEnable(triggerEnable),
		.delayDuration(dlyD), .attackDuration(atkD),
		.firstDecayDuration(d1D), .secondDecayDuration(d2D),
		.firstReleaseDuration(r1D), .secondReleaseDuration(r2D),
		.attackTarget(atkT), .secondDecayTarget(d2T), .sustainTarget(susT),
		.secondReleaseTarget(relT), .invertPolarity(invertPolarity),
		.pitchContour(pitchC), .filterContour(filterC), .ampContour(ampC),
		.ampFeed(ampF));

	// Clock, 100 MHz
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Watchdog, well beyond the planned run
	initial
	begin
		#700000;
		n_errors++;
		complete_run();
	end

	// Model level: clamp to the instance range, scale, flip
	function automatic int expv(input int t, input bit amp, input bit inv);
		int v;
		v = (t > 100) ? 100 : t;
		v = amp ? ((v < 0) ? 0 : v) : ((v < -100) ? -100 : v);
		return inv ? -(v * 256) : v * 256;
	endfunction

	// Pack three targets, pitch in the low byte
	function automatic logic [23:0] pk(input int v[3]);
		return {8'(v[2]), 8'(v[1]), 8'(v[0])};
	endfunction

	// Drive all stage times; nonzero finite times get a small random
	// spread per instance, so the generators do not run in lockstep
	task automatic dur(input int d, a, x1, x2, y1, y2);
		int base[6];
		logic [47:0] f[6];
		base = '{d, a, x1, x2, y1, y2};
		for (int j = 0; j < 6; j++)
			for (int i = 0; i < 3; i++)
				f[j][16*i +: 16] = (base[j] == 0 || base[j] == 16'hffff)
					? 16'(base[j]) : 16'(base[j] + ($random(seed) & 3));
		dlyD = f[0];
		atkD = f[1];
		d1D = f[2];
		d2D = f[3];
		r1D = f[4];
		r2D = f[5];
	endtask

	// Random targets; amp may be negative or above range to test clamps
	task automatic randLev();
		for (int i = 0; i < 3; i++)
		begin
			sT[i] = $random(seed) % 101;
			// Zero would bypass sustain, which has a scenario of its own
			if (sT[i] == 0)
				sT[i] = 1;
			rT[i] = $random(seed) % 101;
			aT[i] = sT[i];
		end
		sT[2] = (sT[2] < 0) ? sT[2] : sT[2] + 20;
		apply();
	endtask

	// Push targets onto the ports
	task automatic apply();
		atkT = pk(aT);
		d2T = pk(sT);
		susT = pk(sT);
		relT = pk(rT);
	endtask

	// Compare the three contours with queued expectations
	task automatic expect3(input int p, f, a);
		logic signed [15:0] got[3];
		int e;
		got = '{pitchC, filterC, ampC};
		expQ.push_back(p);
		expQ.push_back(f);
		expQ.push_back(a);
		for (int i = 0; i < 3; i++)
		begin
			e = expQ.pop_front();
			checks_done++;
			if (got[i] !== 16'(e))
			begin
				n_errors++;
				$display("[ERR] %0t got %h exp %h", $time, got[i], 16'(e));
			end
		end
	endtask

	// Expected sustain of every instance
	task automatic expSus();
		expect3(expv(sT[0], 0, invertPolarity[0]), expv(sT[1], 0, invertPolarity[1]),
			expv(sT[2], 1, 0));
	endtask

	// Pulse the modulation trigger for one clock
	task automatic modPulse();
		modTrigger = 1'b1;
		@(negedge clk);
		modTrigger = 1'b0;
	endtask

	// Verdict and end of run
	task automatic complete_run();
		if (n_errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		seed = 32'h413cbfab;
		n_errors = 0;
		checks_done = 0;
		reset = 1'b1;
		modTrigger = 1'b0;
		triggerEnable = 1'b1;
		triggerMode = 2'h0;
		invertPolarity = 2'h0;
		dur(50, 100, 10, 10, 10, 100);
		randLev();
		repeat (3) @(negedge clk);
		reset = 1'b0;
		expect3(0, 0, 0);
		// Plain held note, then release; two passes, second flipped
		invertPolarity = 2'($random(seed));
		for (int k = 0; k < 2; k++)
		begin
			// Second pass uses the opposite flip on each bipolar generator
			if (k != 0)
				invertPolarity = ~invertPolarity;
			// Enable does not matter in normal mode, so it is randomised
			triggerEnable = 1'($random(seed));
			randLev();
			prt.press();
			prt.waitTicks(20);
			expect3(0, 0, 0);
			prt.waitTicks(250);
			expSus();
			modPulse();
			prt.waitTicks(20);
			expSus();
			prt.letGo();
			prt.waitTicks(300);
			expect3(0, 0, 0);
		end
		invertPolarity = 2'h0;
		// Short attack raised to the floor, decays skipped
		dur(0, 1, 0, 0, 0, 100);
		sT = '{-70, 60, 80};
		aT = sT;
		apply();
		prt.press();
		prt.waitTicks(50);
		checks_done++;
		if ((ampC > 16'sh0000 && ampC < 16'sh5000) !== 1'b1)
		begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, ampC, 16'h2800);
		end
		prt.waitTicks(70);
		expSus();
		prt.letGo();
		prt.waitTicks(250);
		expect3(0, 0, 0);
		// Zero sustain while held
		aT = '{50, -50, 60};
		sT = '{0, 0, 0};
		apply();
		prt.press();
		prt.waitTicks(350);
		expect3(0, 0, 0);
		prt.letGo();
		// Infinite second release holds
		dur(5, 100, 10, 10, 10, 16'hffff);
		randLev();
		prt.press();
		prt.waitTicks(200);
		prt.letGo();
		for (int k = 0; k < 2; k++)
		begin
			prt.waitTicks(200);
			expect3(expv(rT[0], 0, 0), expv(rT[1], 0, 0), expv(rT[2], 1, 0));
		end
		reset = 1'b1;
		repeat (3) @(negedge clk);
		reset = 1'b0;
		expect3(0, 0, 0);
		// Modulation trigger restarts the attack in both trigger modes
		dur(0, 100, 0, 0, 10, 100);
		aT = '{100, 100, 100};
		sT = '{40, 40, 40};
		apply();
		triggerEnable = 1'b1;
		for (int m = 1; m < 3; m++)
		begin
			triggerMode = 2'(m);
			prt.press();
			prt.waitTicks(150);
			expSus();
			modPulse();
			prt.waitTicks(30);
			checks_done++;
			if ((ampC > 16'sh2800) !== 1'b1)
			begin
				n_errors++;
				$display("[ERR] %0t got %h exp %h", $time, ampC, 16'h2800);
			end
			prt.letGo();
			prt.waitTicks(300);
		end
		checks_done++;
		if (feedFault !== 1'b0)
		begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, feedFault, 1'b0);
		end
		complete_run();
	end
endmodule

`default_nettype wire
